// *** pib_irq_bank.sv ***
// Peripheral interrupt enable and flag bank with an AXI4-Lite slave.
// Assumes event inputs are one-cycle pulses synchronous to i_clk_sys and
// that the core applies its own global sequencing to o_core_irq_req.
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pib_consts.svh"

// What this block does
// - Enable bit passes or blocks source request
// - Enable seven high nibble: scanner, checksum, memory, oscillator
// - Enable seven low bits: wavegens; bit 3 zero
// - Enable eight bits 5-3: second timer; 7-6 zero
// - Enable eight bits 2-0: first measurement timer
// - All enable and flag bits reset clear
// - Timer zero overflow flag sticky until written
// - Pin-change summary is OR of port flags
// - External pin flag set by event, software clears
// - Oscillator fail-safe flag sticky until cleared
// - Clock switch flag sticky until cleared
// - Converter threshold and done flags, software clears
// - Flags set regardless of any enable
// - Unimplemented flag positions always read zero
module pib_irq_bank
    import pib_pkg::*;
#(
    parameter int PORT_COUNT = `PIB_PORT_COUNT
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // AXI4-Lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Hardware events
    input wire logic i_timer_zero_overflow,
    input wire logic i_external_pin_event,
    input wire logic [PORT_COUNT-1:0] i_per_port_change_flags,
    input wire logic i_osc_failsafe_event,
    input wire logic i_clock_switch_event,
    input wire logic i_converter_threshold_event,
    input wire logic i_converter_done_event,
    // Flags kept elsewhere for the seventh and eighth enable sets
    input wire logic [7:0] i_flags_seven,
    input wire logic [7:0] i_flags_eight,
    // Enables kept elsewhere for the status zero and request one flags
    input wire logic [7:0] i_status_zero_en,
    input wire logic [7:0] i_request_one_en,
    input wire logic i_global_irq_enable,
    // Requests to the core
    output logic [7:0] o_req_seven,
    output logic [7:0] o_req_eight,
    output logic [7:0] o_req_status_zero,
    output logic [7:0] o_req_request_one,
    output logic o_core_irq_req,
    // Bus-side interrupt line
    output logic o_irq
);

    // ======================================================================
    // Register state
    pib_byte_t enable_seven_r;
    pib_byte_t enable_eight_r;
    pib_byte_t status_zero_r;
    pib_byte_t request_one_r;
    pib_event_t event_r;
    pib_event_t mask_r;
    pib_byte_t status_zero_nxt;
    pib_byte_t request_one_nxt;
    pib_event_t event_nxt;
    pib_byte_t st0_set;
    pib_byte_t rq1_set;
    logic pin_change_any;
    logic pin_change_rise;
    pib_byte_t req_seven_nxt;
    pib_byte_t req_eight_nxt;
    pib_byte_t req_status_zero_nxt;
    pib_byte_t req_request_one_nxt;
    logic core_irq_nxt;
    logic irq_nxt;

    // ======================================================================
    // Bus handshake state
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    pib_resp_t bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    pib_resp_t rresp_r;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    logic aw_hold_nxt;
    logic w_hold_nxt;
    logic bvalid_nxt;
    logic rvalid_nxt;
    logic wr_lane0;
    logic wr_lane1;
    logic wr_known;
    logic rd_known;
    logic [31:0] rd_word;
    logic [7:0] rd_addr;
    logic rd_hit_event;
    logic wr_mask_sel;

    assign aw_take = i_awvalid & awready_r;
    assign w_take = i_wvalid & wready_r;
    assign ar_take = i_arvalid & arready_r;
    assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;
    assign wr_lane0 = do_write & wstrb_r[0];
    assign wr_lane1 = do_write & wstrb_r[1];
    assign aw_hold_nxt = (aw_hold_r & ~do_write) | aw_take;
    assign w_hold_nxt = (w_hold_r & ~do_write) | w_take;
    assign bvalid_nxt = do_write | (bvalid_r & ~i_bready);
    assign rvalid_nxt = ar_take | (rvalid_r & ~i_rready);
    // Byte offsets within a word are ignored; each register is one word
    assign rd_addr = {i_araddr[7:2], 2'b00};
    assign rd_hit_event = ar_take & (rd_addr == `PIB_OFS_EVENT);
    assign wr_mask_sel = do_write & (waddr_r == `PIB_OFS_MASK);

    // Unknown offsets answer with an error and leave every register alone
    always_comb begin
        case (waddr_r)
            `PIB_OFS_ENABLE_SEVEN,
            `PIB_OFS_ENABLE_EIGHT,
            `PIB_OFS_STATUS_ZERO,
            `PIB_OFS_REQUEST_ONE,
            `PIB_OFS_EVENT,
            `PIB_OFS_MASK: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    // ======================================================================
    // Write channel: address and data taken in either order
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `PIB_RESP_OKAY;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            // No new write is taken until the response has been accepted
            awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
            wready_r <= ~w_hold_nxt & ~bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            if (aw_take) begin
                waddr_r <= {i_awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
            end
            if (do_write) begin
                bresp_r <= wr_known ? `PIB_RESP_OKAY : `PIB_RESP_SLVERR;
            end
        end
    end

    // ======================================================================
    // Read channel
    always_comb begin
        rd_known = 1'b1;
        case (rd_addr)
            `PIB_OFS_ENABLE_SEVEN: rd_word = {24'h0, enable_seven_r};
            `PIB_OFS_ENABLE_EIGHT: rd_word = {24'h0, enable_eight_r};
            `PIB_OFS_STATUS_ZERO: rd_word = {24'h0, status_zero_r};
            `PIB_OFS_REQUEST_ONE: rd_word = {24'h0, request_one_r};
            `PIB_OFS_EVENT: rd_word = {16'h0, event_r};
            `PIB_OFS_MASK: rd_word = {16'h0, mask_r};
            default: begin
                rd_word = 32'h0000_0000;
                rd_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `PIB_RESP_OKAY;
        end else begin
            // Only one read is open: the address waits until data is taken
            arready_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_take) begin
                rdata_r <= rd_word;
                rresp_r <= rd_known ? `PIB_RESP_OKAY : `PIB_RESP_SLVERR;
            end
        end
    end

    // ======================================================================
    // Enable registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            enable_seven_r <= `PIB_RST_BYTE;
            enable_eight_r <= `PIB_RST_BYTE;
        end else if (wr_lane0) begin
            if (waddr_r == `PIB_OFS_ENABLE_SEVEN) begin
                // Bit 3 is never stored, so it reads zero
                enable_seven_r <= wdata_r[7:0] & `PIB_ENABLE_SEVEN_MASK;
            end
            if (waddr_r == `PIB_OFS_ENABLE_EIGHT) begin
                enable_eight_r <= wdata_r[7:0] & `PIB_ENABLE_EIGHT_MASK;
            end
        end
    end

    // ======================================================================
    // Flag registers
    assign pin_change_any = |i_per_port_change_flags;

    always_comb begin
        st0_set = 8'h00;
        rq1_set = 8'h00;
        // Events land whatever the enables say
        st0_set[`PIB_BIT_TIMER_ZERO] = i_timer_zero_overflow;
        st0_set[`PIB_BIT_EXT_PIN] = i_external_pin_event;
        rq1_set[`PIB_BIT_OSC_FAILSAFE] = i_osc_failsafe_event;
        rq1_set[`PIB_BIT_CLOCK_SWITCH] = i_clock_switch_event;
        rq1_set[`PIB_BIT_CONV_THRESH] = i_converter_threshold_event;
        rq1_set[`PIB_BIT_CONV_DONE] = i_converter_done_event;

        status_zero_nxt = status_zero_r;
        request_one_nxt = request_one_r;
        if (wr_lane0 && waddr_r == `PIB_OFS_STATUS_ZERO) begin
            status_zero_nxt = wdata_r[7:0];
        end
        if (wr_lane0 && waddr_r == `PIB_OFS_REQUEST_ONE) begin
            request_one_nxt = wdata_r[7:0];
        end
        // Hardware set is ORed last so it beats a clearing write
        status_zero_nxt = (status_zero_nxt | st0_set)
            & `PIB_STATUS_ZERO_WR_MASK;
        // Rebuilt from the ports each cycle, so a write never sticks
        status_zero_nxt[`PIB_BIT_PIN_CHANGE] = pin_change_any;
        request_one_nxt = (request_one_nxt | rq1_set)
            & `PIB_REQUEST_ONE_MASK;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            status_zero_r <= `PIB_RST_BYTE;
            request_one_r <= `PIB_RST_BYTE;
        end else begin
            status_zero_r <= status_zero_nxt;
            request_one_r <= request_one_nxt;
        end
    end

    // ======================================================================
    // Bus interrupt: sticky event bits cleared by reading them
    // A summary that stays high must not refill its bit after a read,
    // so only its rising edge counts as a pin-change event
    assign pin_change_rise = pin_change_any
        & ~status_zero_r[`PIB_BIT_PIN_CHANGE];

    always_comb begin
        event_nxt = event_r;
        if (rd_hit_event) begin
            event_nxt = `PIB_RST_EVENT;
        end
        // Sets are ORed after the clear so a read never loses an event
        event_nxt = event_nxt | {rq1_set, st0_set};
        event_nxt[`PIB_BIT_PIN_CHANGE] = event_nxt[`PIB_BIT_PIN_CHANGE]
            | pin_change_rise;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            event_r <= `PIB_RST_EVENT;
        end else begin
            event_r <= event_nxt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            mask_r <= `PIB_RST_EVENT;
        end else if (wr_mask_sel) begin
            // Lane 1 carries the request one half of the shared layout
            if (wr_lane0) begin
                mask_r[7:0] <= wdata_r[7:0];
            end
            if (wr_lane1) begin
                mask_r[15:8] <= wdata_r[15:8];
            end
        end
    end

    // ======================================================================
    // Request terms shared by the per-source outputs and the core line
    // Flags seven and eight are levels owned elsewhere; not latched here
    assign req_seven_nxt = i_flags_seven & enable_seven_r;
    assign req_eight_nxt = i_flags_eight & enable_eight_r;
    assign req_status_zero_nxt = status_zero_r
        & i_status_zero_en;
    assign req_request_one_nxt = request_one_r
        & i_request_one_en;
    // The global enable gates only the core line; per-source requests
    // still show which source is pending while interrupts are held off
    assign core_irq_nxt = i_global_irq_enable
        & (|{req_seven_nxt, req_eight_nxt,
        req_status_zero_nxt, req_request_one_nxt});
    assign irq_nxt = |(event_r & mask_r);

    // ======================================================================
    // Requests to the core, one cycle behind the flags and enables.
    // Enable-gated only; flags stay visible when disabled.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_req_seven <= 8'h00;
            o_req_eight <= 8'h00;
            o_req_status_zero <= 8'h00;
            o_req_request_one <= 8'h00;
            o_core_irq_req <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_req_seven <= req_seven_nxt;
            o_req_eight <= req_eight_nxt;
            o_req_status_zero <= req_status_zero_nxt;
            o_req_request_one <= req_request_one_nxt;
            o_core_irq_req <= core_irq_nxt;
            o_irq <= irq_nxt;
        end
    end

    // ======================================================================
    // Bus outputs
    assign o_awready = awready_r;
    assign o_wready = wready_r;
    assign o_bvalid = bvalid_r;
    assign o_bresp = bresp_r;
    assign o_arready = arready_r;
    assign o_rvalid = rvalid_r;
    assign o_rdata = rdata_r;
    assign o_rresp = rresp_r;

endmodule
`default_nettype wire

// *** pib_consts.svh ***
// Offsets, field positions, reset values and widths of the interrupt bank.
// Included by the package and by the bank itself; definitions only.
`ifndef PIB_CONSTS_SVH
`define PIB_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define PIB_OFS_ENABLE_SEVEN 8'h00
`define PIB_OFS_ENABLE_EIGHT 8'h04
`define PIB_OFS_STATUS_ZERO 8'h08
`define PIB_OFS_REQUEST_ONE 8'h0C
`define PIB_OFS_EVENT 8'h10
`define PIB_OFS_MASK 8'h14

// ==========================================================================
// Implemented bits of each register
`define PIB_ENABLE_SEVEN_MASK 8'hF7
`define PIB_ENABLE_EIGHT_MASK 8'h3F
`define PIB_STATUS_ZERO_MASK 8'h31
`define PIB_REQUEST_ONE_MASK 8'hC3
`define PIB_STATUS_ZERO_WR_MASK 8'h21

// ==========================================================================
// Field positions
`define PIB_BIT_TIMER_ZERO 5
`define PIB_BIT_PIN_CHANGE 4
`define PIB_BIT_EXT_PIN 0
`define PIB_BIT_OSC_FAILSAFE 7
`define PIB_BIT_CLOCK_SWITCH 6
`define PIB_BIT_CONV_THRESH 1
`define PIB_BIT_CONV_DONE 0

// ==========================================================================
// Reset values and bus answers
`define PIB_RST_BYTE 8'h00
`define PIB_RST_EVENT 16'h0000
`define PIB_RESP_OKAY 2'h0
`define PIB_RESP_SLVERR 2'h2
`define PIB_PORT_COUNT 5

`endif

// *** pib_pkg.sv ***
// Types shared by the peripheral interrupt bank.
// Assumes the constants header sits in the same folder.
`include "pib_consts.svh"

package pib_pkg;
    typedef logic [7:0] pib_byte_t;
    typedef logic [15:0] pib_event_t;
    typedef logic [1:0] pib_resp_t;
endpackage

// *** pib_periph_model.sv ***
// Event source standing in for the peripherals around the bank.
// Assumes the bench asks for events with a one-cycle fire mask.
`timescale 1ns/10ps
`default_nettype none
module pib_periph_model (
    // Clock and requests from the bench
    input wire logic i_clk_sys,
    input wire logic [5:0] i_fire,
    // Event pulses: timer, pin, failsafe, switch, threshold, done
    output logic [5:0] o_pulse
);
    // ======
    // Events
    // Registered so each pulse is clean and one cycle behind its fire bit; it lasts as long as the fire bit
    always_ff @(posedge i_clk_sys) begin
        o_pulse <= i_fire;
    end
endmodule
`default_nettype wire

// *** pib_irq_bank_sva.sv ***
// Checker on the interrupt bank top ports.
// Assumes one clock domain; bound at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module pib_irq_bank_sva
    import pib_pkg::*;
#(
    parameter int PORT_COUNT = 5
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Causes
    input wire logic i_timer_zero_overflow,
    input wire logic [PORT_COUNT-1:0] i_per_port_change_flags,
    input wire logic [7:0] i_flags_seven,
    input wire logic [7:0] i_status_zero_en,
    input wire logic [7:0] i_request_one_en,
    input wire logic i_global_irq_enable,
    // Requests
    input wire logic [7:0] o_req_seven,
    input wire logic [7:0] o_req_eight,
    input wire logic [7:0] o_req_status_zero,
    input wire logic [7:0] o_req_request_one,
    input wire logic o_core_irq_req,
    input wire logic o_irq
);
    // ==========
    // Properties
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    a_req_needs_en: assert property (
        (o_req_request_one & ~$past(i_request_one_en)) == 8'h00)
        else $error("request without enable");
    a_req_needs_flag: assert property (
        (o_req_seven & ~$past(i_flags_seven)) == 8'h00)
        else $error("request without flag");
    a_unimpl_zero: assert property (
        {o_req_seven[3], o_req_eight[7:6], o_req_status_zero[7:6],
         o_req_status_zero[3:1], o_req_request_one[5:2]} == 12'h000)
        else $error("unimplemented bit set");
    a_timer_req: assert property (
        i_timer_zero_overflow && i_status_zero_en[5] ##1 i_status_zero_en[5]
        |=> o_req_status_zero[5])
        else $error("timer overflow lost");
    // Three cycles allow for the summary stage ahead of the request
    a_pin_follow: assert property (
        (|i_per_port_change_flags && i_status_zero_en[4]) [*3]
        |=> o_req_status_zero[4])
        else $error("pin change not summarised");
    a_pin_clear: assert property (
        (!(|i_per_port_change_flags)) [*3] |=> !o_req_status_zero[4])
        else $error("pin change summary stuck");
    a_core_global: assert property (
        o_core_irq_req |-> $past(i_global_irq_enable))
        else $error("core request without global enable");
    a_reset_clear: assert property (
        disable iff (1'b0) !i_rst_b |=> o_req_seven == 8'h00
        && o_req_status_zero == 8'h00 && o_req_request_one == 8'h00
        && !o_core_irq_req && !o_irq)
        else $error("outputs not clear after reset");
endmodule
bind pib_irq_bank pib_irq_bank_sva #(.PORT_COUNT(PORT_COUNT)) u_sva (
    .i_clk_sys, .i_rst_b, .i_timer_zero_overflow, .i_per_port_change_flags,
    .i_flags_seven, .i_status_zero_en, .i_request_one_en,
    .i_global_irq_enable, .o_req_seven, .o_req_eight, .o_req_status_zero,
    .o_req_request_one, .o_core_irq_req, .o_irq
);
`default_nettype wire

// *** tb_peripheral_irq_enable_flag_bank.sv ***
// Bench for the interrupt bank: bus tasks, scoreboard and event model.
// Assumes the bank, its package and header, checker and model files.
`timescale 1ns/10ps
`default_nettype none
`include "pib_consts.svh"
module tb_peripheral_irq_enable_flag_bank;
    import pib_pkg::*;
    // =======
    // Signals
    localparam pib_byte_t e7 = `PIB_OFS_ENABLE_SEVEN;
    localparam pib_byte_t e8 = `PIB_OFS_ENABLE_EIGHT;
    localparam pib_byte_t s0 = `PIB_OFS_STATUS_ZERO;
    localparam pib_byte_t q1 = `PIB_OFS_REQUEST_ONE;
    localparam pib_byte_t ev = `PIB_OFS_EVENT;
    logic clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
    logic arv = 1'b0, rry = 1'b0, glb = 1'b0;
    logic awr, wrdy, bv, arr, rv, core, irq;
    pib_byte_t awa = 8'h00, ara = 8'h00, fl7 = 8'h00, fl8 = 8'h00;
    pib_byte_t en0 = 8'h00, en1 = 8'h00, r7, r8, r0, r1;
    logic [31:0] wd = 32'h0, rdat, d7, d8;
    logic [3:0] ws = 4'h0;
    pib_resp_t br, rr;
    logic [4:0] ports = 5'h00;
    logic [5:0] fire = 6'h00, pulse;
    int bad_count = 0, check_count = 0, seed = 32'h7C549E6B;
    logic [33:0] rq[$];
    pib_resp_t bq[$];
    initial begin
        forever #20 clk = ~clk;
    end
    pib_irq_bank DUT (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_awvalid(awv), .o_awready(awr),
        .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd),
        .i_wstrb(ws), .o_bvalid(bv), .i_bready(bry), .o_bresp(br),
        .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
        .i_rready(rry), .o_rdata(rdat), .o_rresp(rr),
        .i_timer_zero_overflow(pulse[5]), .i_external_pin_event(pulse[4]),
        .i_per_port_change_flags(ports), .i_osc_failsafe_event(pulse[3]),
        .i_clock_switch_event(pulse[2]),
        .i_converter_threshold_event(pulse[1]),
        .i_converter_done_event(pulse[0]), .i_flags_seven(fl7),
        .i_flags_eight(fl8), .i_status_zero_en(en0), .i_request_one_en(en1),
        .i_global_irq_enable(glb), .o_req_seven(r7), .o_req_eight(r8),
        .o_req_status_zero(r0), .o_req_request_one(r1),
        .o_core_irq_req(core), .o_irq(irq)
    );
    pib_periph_model u_model (.i_clk_sys(clk), .i_fire(fire), .o_pulse(pulse));
    // =====
    // Tasks
    task automatic chk(input string nm, input logic [33:0] e,
                       input logic [33:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Fire goes with the write so the event meets the register update
    task automatic wr(input pib_byte_t a, input logic [31:0] d,
                      input pib_resp_t e = 2'h0, input logic [5:0] f = 6'h00);
        bit ta = 1'b0, tw = 1'b0;
        @(posedge clk);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= d;
        ws <= 4'hF;
        bry <= 1'b1;
        fire <= f;
        bq.push_back(e);
        while (!(ta && tw)) begin
            @(posedge clk);
            fire <= 6'h00;
            if (awv && awr) begin
                ta = 1'b1;
                awv <= 1'b0;
            end
            if (wv && wrdy) begin
                tw = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (!bv);
        bry <= 1'b0;
    endtask
    task automatic rd(input pib_byte_t a, input logic [31:0] d,
                      input pib_resp_t e = 2'h0);
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        rq.push_back({e, d});
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rry <= 1'b0;
    endtask
    task automatic fire_ev(input logic [5:0] f);
        @(posedge clk);
        fire <= f;
        @(posedge clk);
        fire <= 6'h00;
        repeat (3) @(posedge clk);
    endtask
    // ==========
    // Scoreboard
    always @(posedge clk) begin
        if (rv && rry) begin
            chk("rdata", rq.pop_front(), {rr, rdat});
        end
        if (bv && bry) begin
            chk("bresp", 34'(bq.pop_front()), 34'(br));
        end
    end
    // Run takes a few hundred cycles; the limit leaves wide margin
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test;
    end
    // =========
    // Scenarios
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 24; a += 4) begin
            rd(8'(a), 32'h0);
        end
        rd(8'h18, 32'h0, `PIB_RESP_SLVERR);
        wr(8'h18, 32'hFF, `PIB_RESP_SLVERR);
        repeat (4) begin
            d7 = $random(seed);
            d8 = $random(seed);
            wr(e7, d7);
            wr(e8, d8);
            rd(e7, 32'(d7[7:0] & 8'hF7));
            rd(e8, 32'(d8[7:0] & 8'h3F));
        end
        fl7 <= 8'($random(seed));
        fl8 <= 8'($random(seed));
        glb <= 1'b1;
        repeat (3) @(posedge clk);
        chk("req_seven", 34'(fl7 & d7[7:0] & 8'hF7), 34'(r7));
        chk("req_eight", 34'(fl8 & d8[7:0] & 8'h3F), 34'(r8));
        wr(s0, 32'h0);
        wr(q1, 32'h0);
        fire_ev(6'h3F);
        rd(s0, 32'h21);
        rd(q1, 32'hC3);
        chk("req_zero", 34'h0, 34'(r0));
        en0 <= 8'hFF;
        en1 <= 8'hFF;
        repeat (3) @(posedge clk);
        chk("req_zero", 34'h21, 34'(r0));
        chk("req_one", 34'hC3, 34'(r1));
        chk("core_req", 34'h1, 34'(core));
        rd(ev, 32'hC321);
        wr(s0, 32'h0, 2'h0, 6'h20);
        rd(s0, 32'h20);
        wr(q1, 32'h0);
        rd(q1, 32'h0);
        wr(s0, 32'h0);
        for (int i = 0; i < 5; i++) begin
            ports <= 5'(1 << i);
            repeat (3) @(posedge clk);
            rd(s0, 32'h10);
        end
        wr(s0, 32'h0);
        rd(s0, 32'h10);
        ports <= 5'h00;
        repeat (3) @(posedge clk);
        rd(s0, 32'h0);
        rd(ev, 32'h30);
        wr(`PIB_OFS_MASK, 32'h20, 2'h0, 6'h10);
        rd(`PIB_OFS_MASK, 32'h20);
        chk("irq", 34'h0, 34'(irq));
        fire_ev(6'h20);
        chk("irq", 34'h1, 34'(irq));
        rd(ev, 32'h21);
        repeat (2) @(posedge clk);
        chk("irq", 34'h0, 34'(irq));
        wr(`PIB_OFS_MASK, 32'h8000);
        fire_ev(6'h08);
        chk("irq", 34'h1, 34'(irq));
        rd(ev, 32'h8000);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk("req_zero", 34'h0, 34'(r0));
        rst_b <= 1'b1;
        @(posedge clk);
        rd(e7, 32'h0);
        finish_test;
    end
endmodule
`default_nettype wire
